//--- core/dac_variable_monitor.sv
// Variable monitor: register slave, variable selection, scaling and analog monitor code.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Speed integral gain view, 10 bits, read-only in bits 31-16.
// RULE2 - Speed proportional gain view, 10 bits, read-only in bits 15-0.
// RULE3 - Speed gain readback at F2h, zero after reset until gains load.
// RULE4 - Bits 11-0 hold the read/write address of the monitored variable.
// RULE5 - Nonzero linear scale N multiplies the variable by N/8.
// RULE6 - Linear scale zero treats the variable as enum, maximum 31.
// RULE7 - Enum mode multiplies by two to the power-of-two scale field.
// RULE8 - Unipolar: 0 pu gives 0 V, 1 pu gives 3 V.
// RULE9 - Bipolar: -1 pu gives 0 V, +1 pu gives 3 V, 1.5 V centre.
// RULE10 - Control at 1D4h resets to 00110000h; bits 31-21 read zero.
// RULE11 - Linear divisor is eight, not sixteen.
// RULE12 - Out-of-range values saturate at 0 V or 3 V.
module dac_variable_monitor
  import monitor_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t req,
  output logic [31:0] rdata,
  input wire speed_gain_t gain_in,
  input wire logic gain_load,
  output logic [11:0] variable_select,
  input wire logic signed [15:0] variable_value,
  output logic [11:0] analog_monitor_pin
);
  typedef struct packed {
    monitor_ctrl_t ctrl;
    speed_gain_t gains;
    logic [31:0] rdata;
    logic [11:0] dac;
    logic [11:0] sel;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic signed [17:0] scaled_pu;
  logic [11:0] dac_code;

  monitor_scaler scaler_i (
    .variable_value(variable_value),
    .ctrl(state_reg.ctrl),
    .scaled_pu(scaled_pu)
  );

  monitor_dac_map map_i (
    .scaled_pu(scaled_pu),
    .unipolar(state_reg.ctrl.polarity_select),
    .dac_code(dac_code)
  );

  function automatic logic [31:0] gain_word(input speed_gain_t g);
    gain_word = '0;
    gain_word[ki_lsb +: gain_width] = g.integral; // see RULE1
    gain_word[kp_lsb +: gain_width] = g.proportional; // see RULE2
  endfunction

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = '0;
    if (gain_load)
      state_next.gains = gain_in; // see RULE3
    if (req.write && req.addr == monitor_ctrl_offset)
    begin
      state_next.ctrl.variable_address = req.wdata[addr_lsb +: 12]; // see RULE4
      state_next.ctrl.polarity_select = req.wdata[polarity_bit];
      state_next.ctrl.linear_scale = req.wdata[linear_lsb +: 4];
      state_next.ctrl.power_of_two_scale = req.wdata[pow2_lsb +: 4];
    end
    if (req.read)
    begin
      // Unmapped addresses read zero; the gain view ignores writes.
      if (req.addr == speed_gain_offset)
        state_next.rdata = gain_word(state_reg.gains); // see RULE3
      else if (req.addr == monitor_ctrl_offset)
        state_next.rdata = 32'(state_reg.ctrl) & monitor_ctrl_mask; // see RULE10
    end
    // One cycle of selection latency; the code follows the returned value.
    state_next.sel = state_reg.ctrl.variable_address;
    state_next.dac = dac_code;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg.ctrl <= monitor_ctrl_t'(monitor_ctrl_reset[20:0]); // see RULE10
      state_reg.gains <= speed_gain_t'(20'h00000);
      state_reg.rdata <= 32'h00000000;
      state_reg.dac <= dac_mid_code;
      state_reg.sel <= 12'h000;
    end
    else
      state_reg <= state_next;
  end

  assign rdata = state_reg.rdata;
  assign variable_select = state_reg.sel;
  assign analog_monitor_pin = state_reg.dac;
endmodule // dac_variable_monitor
`default_nettype wire

//--- core/monitor_dac_map.sv
// Maps a per-unit value onto a 12-bit code for the 0 V to 3 V monitor pin.
`timescale 1ns/1ps
`default_nettype none
module monitor_dac_map
  import monitor_pkg::*;
(
  input wire logic signed [17:0] scaled_pu,
  input wire logic unipolar,
  output logic [11:0] dac_code
);
  logic signed [19:0] code;
  always_comb
  begin
    if (unipolar)
      code = 20'(scaled_pu) >>> 3; // see RULE8
    else
      code = (20'(scaled_pu) >>> 4) + 20'sd2048; // see RULE9
    if (code < 20'sd0)
      dac_code = 12'h000; // see RULE12
    else if (code > 20'sd4095)
      dac_code = dac_full_code; // see RULE12
    else
      dac_code = code[11:0];
  end
endmodule // monitor_dac_map
`default_nettype wire

//--- core/monitor_pkg.sv
// Package with register map, field layout, reset values and carriers for the variable monitor.
package monitor_pkg;
  localparam logic [11:0] speed_gain_offset = 12'h0F2;
  localparam logic [11:0] monitor_ctrl_offset = 12'h1D4;
  localparam logic [31:0] speed_gain_reset = 32'h00000000;
  localparam logic [31:0] monitor_ctrl_reset = 32'h00110000;
  localparam logic [31:0] monitor_ctrl_mask = 32'h001FFFFF;
  localparam int ki_lsb = 16;
  localparam int kp_lsb = 0;
  localparam int gain_width = 10;
  localparam int addr_lsb = 0;
  localparam int polarity_bit = 12;
  localparam int linear_lsb = 13;
  localparam int pow2_lsb = 17;
  localparam int linear_shift = 3;
  localparam logic [15:0] enum_max = 16'h001F;
  localparam logic [11:0] dac_full_code = 12'hFFF;
  localparam logic [11:0] dac_mid_code = 12'h800;
  localparam int var_frac = 15;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] power_of_two_scale;
    logic [3:0] linear_scale;
    logic polarity_select;
    logic [11:0] variable_address;
  } monitor_ctrl_t;

  typedef struct packed {
    logic [9:0] integral;
    logic [9:0] proportional;
  } speed_gain_t;
endpackage

//--- core/monitor_scaler.sv
// Combinational scaling of the monitored variable into a per-unit value with saturation.
`timescale 1ns/1ps
`default_nettype none
module monitor_scaler
  import monitor_pkg::*;
(
  input wire logic signed [15:0] variable_value,
  input wire monitor_ctrl_t ctrl,
  output logic signed [17:0] scaled_pu
);
  function automatic logic signed [17:0] clamp18(input logic signed [47:0] v);
    if (v > 48'sd65535)
      clamp18 = 18'sd65535;
    else if (v < -48'sd65536)
      clamp18 = -18'sd65536;
    else
      clamp18 = v[17:0];
  endfunction

  logic signed [47:0] product;
  always_comb
  begin
    product = '0;
    if (ctrl.linear_scale != 4'h0)
    begin
      // Divisor of eight chosen over the conflicting sixteen. see RULE11
      product = (48'(variable_value) * 48'(signed'({1'b0, ctrl.linear_scale}))) >>> linear_shift; // see RULE5
    end
    else
    begin
      // Enum value up to 31 mapped onto full scale, then the power-of-two gain. see RULE6
      product = (48'(variable_value) <<< ctrl.power_of_two_scale) * 48'sd1057; // see RULE7
    end
    scaled_pu = clamp18(product); // see RULE12
  end
endmodule // monitor_scaler
`default_nettype wire

//--- testbench/dac_variable_monitor_asserts.sv
// Port checker of the variable monitor.
`timescale 1ns/1ps
`default_nettype none
module mon_chk import monitor_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t req,
  input wire logic [31:0] rdata,
  input wire speed_gain_t gain_in,
  input wire logic gain_load,
  input wire logic [11:0] variable_select,
  input wire logic signed [15:0] variable_value,
  input wire logic [11:0] analog_monitor_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cw; req.write && req.addr == monitor_ctrl_offset; endsequence
  property p_rz; !$past(req.read) |-> rdata == 0; endproperty
  a_rz: assert property (p_rz) else $error("rdata");
  property p_sel; s_cw |-> ##2 variable_select == $past(req.wdata[11:0], 2); endproperty
  a_sel: assert property (p_sel) else $error("sel");
  property p_keep; !$past(req.write, 2) |-> $stable(variable_select); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_ctl; s_cw ##1 !req.write ##1 req.read && req.addr == monitor_ctrl_offset
    |=> rdata == ($past(req.wdata, 3) & monitor_ctrl_mask); endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  property p_rsv; req.read && req.addr == monitor_ctrl_offset |=> rdata[31:21] == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_gain; gain_load ##1 !gain_load ##1 req.read && req.addr == speed_gain_offset && !gain_load
    |=> rdata == {6'h00, $past(gain_in.integral, 3), 6'h00, $past(gain_in.proportional, 3)}; endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_hold; !req.write ##1 $stable(variable_value) |=> $stable(analog_monitor_pin); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_mid; $fell(rst) |-> analog_monitor_pin == dac_mid_code; endproperty
  a_mid: assert property (p_mid) else $error("mid");
endmodule // mon_chk
`default_nettype wire

//--- testbench/test_dac_variable_monitor.sv
// Self-checking bench of the variable monitor.
`timescale 1ns/1ps
`default_nettype none
module test_dac_variable_monitor import monitor_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, gain_load = 1'b0;
  reg_req_t req = '0;
  speed_gain_t gain_in = '0;
  logic [31:0] rdata;
  logic [11:0] variable_select, analog_monitor_pin;
  logic signed [15:0] variable_value;
  int mismatches = 0, checks_done = 0, cyc = 0;
  logic [31:0] tc [8] = '{32'h111400, 32'h110400, 32'h109400, 32'h103400, 32'h11F7FF, 32'h11E800, 32'h1E1001, 32'h0};
  logic [11:0] te [8] = '{12'h800, 12'hC00, 12'h400, 12'h100, 12'hFFF, 12'h000, 12'hFFF, 12'h800};
  always #50 clk = ~clk;
  dac_variable_monitor uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .gain_in(gain_in), .gain_load(gain_load),
    .variable_select(variable_select), .variable_value(variable_value), .analog_monitor_pin(analog_monitor_pin));
  var_store store (.variable_select(variable_select), .variable_value(variable_value));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    mismatches += (got !== exp);
    if (got !== exp) $display("wrong value %s expected %h seen %h", what, exp, got);
  endtask
  // Read data stand one cycle only, so they are compared just after the taking edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, w, !w};
    @(posedge clk);
    req <= '{a, d, 1'b0, 1'b0};
    #1 if (!w) chk(rdata, d, "rdata");
  endtask
  task automatic t_regs;
    bus(1'b0, speed_gain_offset, 32'h0);
    bus(1'b0, monitor_ctrl_offset, 32'h00110000);
    @(posedge clk);
    gain_in <= '{10'h3A5, 10'h15A};
    gain_load <= 1'b1;
    @(posedge clk);
    gain_load <= 1'b0;
    bus(1'b0, speed_gain_offset, 32'h03A5015A);
    bus(1'b1, speed_gain_offset, 32'hFFFFFFFF);
    bus(1'b0, speed_gain_offset, 32'h03A5015A);
    bus(1'b1, monitor_ctrl_offset, 32'hFFFFFFFF);
    bus(1'b0, monitor_ctrl_offset, 32'h001FFFFF);
    chk({20'h0, variable_select}, 32'hFFF, "sel");
    bus(1'b0, 12'h100, 32'h0);
  endtask
  task automatic t_map;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, monitor_ctrl_offset, tc[i]);
      repeat (2) @(posedge clk);
      #1 chk({20'h0, analog_monitor_pin}, {20'h0, te[i]}, "pin");
    end
  endtask
  task automatic results(input logic late);
    mismatches += late;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
    if (++cyc == 500) results(1'b1);
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_map();
    results(1'b0);
  end
endmodule // test_dac_variable_monitor
bind dac_variable_monitor mon_chk chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .gain_in(gain_in),
  .gain_load(gain_load), .variable_select(variable_select), .variable_value(variable_value),
  .analog_monitor_pin(analog_monitor_pin));
`default_nettype wire

//--- testbench/var_store.sv
// Variable store; an address returns itself in the top bits, so one address picks any level.
`timescale 1ns/1ps
`default_nettype none
module var_store (
  input wire logic [11:0] variable_select,
  output logic signed [15:0] variable_value
);
  assign variable_value = {variable_select, 4'h0};
endmodule // var_store
`default_nettype wire
